// [src/rffe_switch_power_state_control.sv]
`timescale 1ns/1ps
module rffe_switch_power_state_control
    import rffe_switch_pkg::*;
#(
    parameter logic [3:0] SLAVE_ID = 4'h7 // Arbitrary value
)
(
    input wire logic clock_in, // System clock, 50 MHz
    input wire logic rst_in, // Synchronous reset, active high
    input wire logic sclk_in, // Serial bus clock from the master
    input wire logic sdata_in, // Serial bus data from the master
    input wire logic vio_in, // Interface supply present, high = up
    output logic [THROWS-1:0] bank_a_throw_port_out, // Bank A path, one-hot or all open
    output logic [THROWS-1:0] bank_b_throw_port_out, // Bank B path, one-hot or all open
    output logic paths_valid_out, // High when path outputs are determinate
    output logic charge_pump_en_out, // Charge pump running
    output logic slave_active_out, // Bus slave answering commands
    output logic [1:0] state_out // Current operating state code
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------

    // Both parity checks take 13-bit words; the data check pads with zeros,
    // which leave the count of ones unchanged
    // True when the word plus its parity bit holds an odd count of ones
    function automatic logic odd_ok(input logic [12:0] v);
        odd_ok = (^v) == 1'b1;
    endfunction : odd_ok

    // Throw select 1..6 maps to one path; 0 and 7 leave all paths open
    function automatic logic [THROWS-1:0] throw_onehot(input logic [2:0] sel);
        logic [THROWS-1:0] r;
        r = '0;
        case (sel)
            3'h1: r = 6'h01;
            3'h2: r = 6'h02;
            3'h3: r = 6'h04;
            3'h4: r = 6'h08;
            3'h5: r = 6'h10;
            3'h6: r = 6'h20;
            default: r = '0;
        endcase
        throw_onehot = r;
    endfunction : throw_onehot

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic vio_meta;
    logic vio_sync;
    logic tog_meta;
    logic tog_sync;
    logic tog_seen;
    logic [FRAME_W-1:0] frame_word;
    logic frame_toggle;

    op_state_t state;
    op_state_t next_state;
    logic [STARTUP_CNT_W-1:0] startup_cnt;
    logic startup_done;

    logic [2:0] bank_a_sel;
    logic [2:0] bank_b_sel;
    logic [1:0] power_field;

    logic new_frame;
    logic slave_live;
    logic id_match;
    logic frame_ok;
    logic [4:0] wr_addr;
    logic [7:0] wr_data;
    logic power_write;
    logic [1:0] power_req;

    // ------------------------------------------------------------
    // Link side receiver, runs on the master's clock
    // ------------------------------------------------------------
    // The receiver owns no system-side state; it only hands over a word
    // and a toggle, which keeps every crossing into the system clock in one place below
    rffe_frame_rx u_rx (
        .sclk_in(sclk_in),
        .rst_in(rst_in),
        .sdata_in(sdata_in),
        .frame_word_out(frame_word),
        .frame_toggle_out(frame_toggle)
    );

    // ------------------------------------------------------------
    // Crossings into the system clock
    // ------------------------------------------------------------
    // A supply dip shorter than one cycle may be missed; accepted,
    // since the supply is a slow level
    // Supply level from a pin: two flops before anything looks at it
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            vio_meta <= 1'b0;
            vio_sync <= 1'b0;
        end else begin
            vio_meta <= vio_in;
            vio_sync <= vio_meta;
        end
    end

    // Frame event arrives as a toggle; the word is stable by the time it lands
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            tog_meta <= 1'b0;
            tog_sync <= 1'b0;
            tog_seen <= 1'b0;
        end else begin
            tog_meta <= frame_toggle;
            tog_sync <= tog_meta;
            tog_seen <= tog_sync;
        end
    end

    // Latency from the closing sclk edge:
    //   Edge 1: toggle in the first flop
    //   Edge 2: toggle in the second flop, frame decoded
    //   Edge 3: register or state updated
    //   Edge 4: outputs follow
    // Frames end at least 23 sclk periods apart, far above this latency,
    // so one held word serves one event at a time
    assign new_frame = tog_sync ^ tog_seen;

    // ------------------------------------------------------------
    // Command decoder
    // ------------------------------------------------------------
    // Frame word, first bit received at the top:
    //   Bits 21..18: slave address, broadcast 0 also taken
    //   Bits 17..15: command, only register write acts
    //   Bits 14..10: register address
    //   Bit 9: header parity, odd over bits 21..9
    //   Bits 8..1: write data
    //   Bit 0: data parity, odd over bits 8..0
    // Unknown addresses are ignored without any trace
    // Frames are dropped in shutdown and startup: the slave is not listening
    assign slave_live = (state == ST_ACTIVE) || (state == ST_LOW_POWER);
    assign id_match = (frame_word[SA_MSB:SA_LSB] == SLAVE_ID)
        || (frame_word[SA_MSB:SA_LSB] == SA_BROADCAST);
    assign wr_addr = frame_word[ADDR_MSB:ADDR_LSB];
    assign wr_data = frame_word[DATA_MSB:DATA_LSB];

    // A parity slip discards the whole frame rather than half-applying it
    assign frame_ok = new_frame && slave_live && id_match
        && (frame_word[CMD_MSB:CMD_LSB] == CMD_REG_WRITE)
        && odd_ok(frame_word[SA_MSB:HDR_PAR_POS])
        && odd_ok({4'h0, frame_word[DATA_MSB:DATA_PAR_POS]});

    assign power_write = frame_ok && (wr_addr == REG_POWER);
    assign power_req = wr_data[PWR_MSB:PWR_LSB];

    // ------------------------------------------------------------
    // Switch-control and power registers
    // ------------------------------------------------------------
    // Map: bank A select, bank B select, power field; bank selects
    // survive low power, only startup or shutdown clear them
    // Startup keeps every register at its default while it lasts
    always_ff @(posedge clock_in) begin
        if (rst_in || state == ST_STARTUP || state == ST_SHUTDOWN) begin
            bank_a_sel <= BANK_SEL_RESET;
            bank_b_sel <= BANK_SEL_RESET;
        end else if (frame_ok) begin
            if (wr_addr == REG_BANK_A) begin
                bank_a_sel <= wr_data[SEL_MSB:SEL_LSB];
            end
            if (wr_addr == REG_BANK_B) begin
                bank_b_sel <= wr_data[SEL_MSB:SEL_LSB];
            end
        end
    end

    // Power field keeps what was written; unused code 3 is stored but moves nothing
    always_ff @(posedge clock_in) begin
        if (rst_in || state == ST_STARTUP || state == ST_SHUTDOWN) begin
            power_field <= POWER_FIELD_RESET;
        end else if (power_write) begin
            power_field <= power_req;
        end
    end

    // ------------------------------------------------------------
    // Startup timer
    // ------------------------------------------------------------
    // The count restarts on every entry, so a repeated startup code
    // always gives the full turn-on time before active
    // Counts the turn-on time while defaults settle
    always_ff @(posedge clock_in) begin
        if (rst_in || state != ST_STARTUP) begin
            startup_cnt <= '0;
        end else if (!startup_done) begin
            startup_cnt <= startup_cnt + 10'h001;
        end
    end

    assign startup_done = (startup_cnt == STARTUP_CNT_W'(STARTUP_CYCLES - 1));

    // ------------------------------------------------------------
    // Operating state machine
    // ------------------------------------------------------------
    // Transition map, supply loss checked first:
    //   Any state, supply low: shutdown
    //   Shutdown, supply up: startup
    //   Startup, timer expired: active
    //   Active, low power code: low power
    //   Active, startup code: startup
    //   Low power, active code: active
    //   Low power, startup code: startup
    //   Code 3 or any other write: no move
    // Supply loss wins over any pending write, from every state
    always_comb begin
        next_state = state;
        if (!vio_sync) begin
            next_state = ST_SHUTDOWN;
        end else begin
            case (state)
                ST_SHUTDOWN: begin
                    next_state = ST_STARTUP;
                end
                ST_STARTUP: begin
                    if (startup_done) begin
                        next_state = ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (power_write && power_req == PWR_LOW) begin
                        next_state = ST_LOW_POWER;
                    end else if (power_write && power_req == PWR_STARTUP) begin
                        next_state = ST_STARTUP;
                    end
                end
                ST_LOW_POWER: begin
                    if (power_write && power_req == PWR_ACTIVE) begin
                        next_state = ST_ACTIVE;
                    end else if (power_write && power_req == PWR_STARTUP) begin
                        next_state = ST_STARTUP;
                    end
                end
                default: begin
                    next_state = ST_SHUTDOWN;
                end
            endcase
        end
    end

    // Four codes and four states, so no illegal code exists;
    // the default branch only guards against unknowns
    // One enum register, so exactly one state holds at a time
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            state <= ST_SHUTDOWN;
        end else begin
            state <= next_state;
        end
    end

    // ------------------------------------------------------------
    // Switch core drive
    // ------------------------------------------------------------
    // Output encoding per bank:
    //   Select 1..6 closes the matching throw, bit 0 is path 1
    //   Select 0 or 7 leaves every throw open
    // Trade-off: open throws stand in for undetermined paths, so the
    // outputs never show a stale selection while the pump is off
    // Paths follow registers only in active; elsewhere all throws open
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            bank_a_throw_port_out <= '0;
            bank_b_throw_port_out <= '0;
            paths_valid_out <= 1'b0;
        end else if (state == ST_ACTIVE) begin
            bank_a_throw_port_out <= throw_onehot(bank_a_sel);
            bank_b_throw_port_out <= throw_onehot(bank_b_sel);
            paths_valid_out <= 1'b1;
        end else begin
            bank_a_throw_port_out <= '0;
            bank_b_throw_port_out <= '0;
            paths_valid_out <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Pump, slave status and state report
    // ------------------------------------------------------------
    // Slave status shows whether frames are taken, so a master can
    // see that writes in shutdown or startup are lost
    // Pump and valid share one condition so they never disagree
    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            charge_pump_en_out <= 1'b0;
            slave_active_out <= 1'b0;
            state_out <= ST_SHUTDOWN;
        end else begin
            charge_pump_en_out <= (state == ST_ACTIVE);
            slave_active_out <= slave_live;
            state_out <= state;
        end
    end

endmodule : rffe_switch_power_state_control

// [shared/rffe_switch_pkg.sv]
package rffe_switch_pkg;

    // ------------------------------------------------------------
    // Operating states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        ST_SHUTDOWN = 2'b00,
        ST_STARTUP = 2'b01,
        ST_ACTIVE = 2'b10,
        ST_LOW_POWER = 2'b11
    } op_state_t;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLOCK_MHZ = 50;
    localparam int STARTUP_TIME_US = 10;
    localparam int STARTUP_CYCLES = STARTUP_TIME_US * CLOCK_MHZ;
    localparam int STARTUP_CNT_W = 10;

    // ------------------------------------------------------------
    // Frame layout, start bit stripped, first bit received is the MSB
    // ------------------------------------------------------------
    localparam int FRAME_W = 22;
    localparam int BIT_CNT_W = 5;
    localparam int SA_MSB = 21;
    localparam int SA_LSB = 18;
    localparam int CMD_MSB = 17;
    localparam int CMD_LSB = 15;
    localparam int ADDR_MSB = 14;
    localparam int ADDR_LSB = 10;
    localparam int HDR_PAR_POS = 9;
    localparam int DATA_MSB = 8;
    localparam int DATA_LSB = 1;
    localparam int DATA_PAR_POS = 0;

    localparam logic [2:0] CMD_REG_WRITE = 3'h2;
    localparam logic [3:0] SA_BROADCAST = 4'h0;

    // ------------------------------------------------------------
    // Register offsets and fields
    // ------------------------------------------------------------
    localparam logic [4:0] REG_BANK_A = 5'h00;
    localparam logic [4:0] REG_BANK_B = 5'h01;
    localparam logic [4:0] REG_POWER = 5'h1C;
    localparam int SEL_MSB = 2;
    localparam int SEL_LSB = 0;
    localparam int PWR_MSB = 7;
    localparam int PWR_LSB = 6;

    localparam logic [2:0] BANK_SEL_RESET = 3'h0;
    localparam logic [1:0] POWER_FIELD_RESET = 2'h0;

    // Power-field codes
    localparam logic [1:0] PWR_ACTIVE = 2'h0;
    localparam logic [1:0] PWR_STARTUP = 2'h1;
    localparam logic [1:0] PWR_LOW = 2'h2;

    localparam int THROWS = 6;

endpackage : rffe_switch_pkg

// [src/rffe_frame_rx.sv]
`timescale 1ns/1ps
module rffe_frame_rx
    import rffe_switch_pkg::*;
(
    input wire logic sclk_in, // Link serial clock
    input wire logic rst_in, // System reset, foreign to this domain
    input wire logic sdata_in, // Serial data, sampled on rising sclk
    output logic [FRAME_W-1:0] frame_word_out, // Last whole frame
    output logic frame_toggle_out // Flips once per whole frame
);

    logic rst_meta;
    logic rst_sync;
    logic [BIT_CNT_W-1:0] bit_cnt;
    logic [FRAME_W-1:0] shift;

    // ------------------------------------------------------------
    // Reset crossing into the link domain
    // ------------------------------------------------------------
    // Reset only lands once sclk runs; a frame cut short stays harmless
    always_ff @(posedge sclk_in) begin
        rst_meta <= rst_in;
        rst_sync <= rst_meta;
    end

    // ------------------------------------------------------------
    // Receive only: this end never drives the data line
    // ------------------------------------------------------------
    // Start bit opens a frame, then FRAME_W bits are shifted in
    always_ff @(posedge sclk_in) begin
        if (rst_sync) begin
            bit_cnt <= '0;
            shift <= '0;
        end else if (bit_cnt == '0) begin
            if (sdata_in) begin
                bit_cnt <= 5'h01;
            end
        end else begin
            shift <= {shift[FRAME_W-2:0], sdata_in};
            if (bit_cnt == BIT_CNT_W'(FRAME_W)) begin
                bit_cnt <= '0;
            end else begin
                bit_cnt <= bit_cnt + 5'h01;
            end
        end
    end

    // Word is held until the next frame ends, so the system side reads it stable
    always_ff @(posedge sclk_in) begin
        if (rst_sync) begin
            frame_word_out <= '0;
            frame_toggle_out <= 1'b0;
        end else if (bit_cnt == BIT_CNT_W'(FRAME_W)) begin
            frame_word_out <= {shift[FRAME_W-2:0], sdata_in};
            frame_toggle_out <= ~frame_toggle_out;
        end
    end

endmodule : rffe_frame_rx

// [sim/rffe_switch_properties.sv]
`timescale 1ns/1ps
module rffe_switch_properties
    import rffe_switch_pkg::*;
(
    input wire logic clock_in, // System clock
    input wire logic rst_in, // Synchronous reset
    input wire logic vio_in, // Interface supply
    input wire logic [THROWS-1:0] bank_a_throw_port_out, // Bank A path
    input wire logic [THROWS-1:0] bank_b_throw_port_out, // Bank B path
    input wire logic paths_valid_out, // Paths determinate
    input wire logic charge_pump_en_out, // Pump running
    input wire logic slave_active_out, // Slave live
    input wire logic [1:0] state_out // State code
);
    // ----------------------------------------
    // Startup length
    // ----------------------------------------
    localparam int START_LO = STARTUP_CYCLES - 2;
    localparam int START_HI = STARTUP_CYCLES + 2;
    logic [11:0] startup_run;

    // Counts cycles spent in startup; slack of two covers the output flop stage
    always_ff @(posedge clock_in) begin
        if (rst_in || state_out != ST_STARTUP) begin
            startup_run <= 12'h000;
        end else begin
            startup_run <= startup_run + 12'h001;
        end
    end

    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    AST_PUMP_ACTIVE_ONLY: assert property (
        charge_pump_en_out == (state_out == ST_ACTIVE)) else $error("pump outside active");
    AST_VALID_IS_PUMP: assert property (
        paths_valid_out == charge_pump_en_out) else $error("paths valid without pump");
    AST_UNDETERMINED_ZERO: assert property (
        !paths_valid_out |-> (bank_a_throw_port_out == 6'h00 && bank_b_throw_port_out == 6'h00))
        else $error("throw driven while undetermined");
    AST_ONE_THROW: assert property (
        $onehot0(bank_a_throw_port_out) && $onehot0(bank_b_throw_port_out))
        else $error("more than one throw");
    AST_SLAVE_LIVE: assert property (
        slave_active_out == (state_out inside {ST_ACTIVE, ST_LOW_POWER}))
        else $error("slave activity wrong");
    AST_STARTUP_LENGTH: assert property (
        (state_out == ST_ACTIVE && $past(state_out) == ST_STARTUP)
        |-> startup_run inside {[START_LO:START_HI]}) else $error("startup length wrong");
    AST_VIO_LOSS: assert property (
        !vio_in [*6] |-> state_out == ST_SHUTDOWN) else $error("no shutdown on supply loss");
    AST_SHUTDOWN_HOLDS: assert property (
        (!vio_in [*3]) ##0 state_out == ST_SHUTDOWN |=> state_out == ST_SHUTDOWN)
        else $error("left shutdown without supply");
    AST_SHUTDOWN_EXIT: assert property (
        ($past(state_out) == ST_SHUTDOWN && state_out != ST_SHUTDOWN)
        |-> state_out == ST_STARTUP) else $error("shutdown left to wrong state");
    AST_ACTIVE_ENTRY: assert property (
        ($changed(state_out) && state_out == ST_ACTIVE)
        |-> $past(state_out) inside {ST_STARTUP, ST_LOW_POWER}) else $error("bad active entry");
endmodule : rffe_switch_properties

bind rffe_switch_power_state_control rffe_switch_properties i_props (
    .clock_in(clock_in), .rst_in(rst_in), .vio_in(vio_in),
    .bank_a_throw_port_out(bank_a_throw_port_out),
    .bank_b_throw_port_out(bank_b_throw_port_out),
    .paths_valid_out(paths_valid_out), .charge_pump_en_out(charge_pump_en_out),
    .slave_active_out(slave_active_out), .state_out(state_out));

// [sim/rffe_bus_master.sv]
`timescale 1ns/1ps
module rffe_bus_master
    import rffe_switch_pkg::*;
(
    output logic sclk_out, // Link clock, still between frames
    output logic sdata_out // Link data, parked low between frames
);
    // ----------------------------------------
    // Bit and frame drivers
    // ----------------------------------------
    localparam realtime HALF = 15.0;

    initial begin
        sclk_out = 1'b0;
        sdata_out = 1'b0;
    end

    // Data moves while the clock is low so the rising edge sees it settled
    task automatic put_bit(input logic b);
        sdata_out = b;
        #HALF sclk_out = 1'b1;
        #HALF sclk_out = 1'b0;
    endtask : put_bit

    task automatic idle(input int n);
        repeat (n) put_bit(1'b0);
    endtask : idle

    // Only the master opens frames; bad flips the header parity on purpose
    task automatic send_frame(input logic [3:0] sa, input logic [2:0] cmd,
        input logic [4:0] addr, input logic [7:0] data, input logic bad);
        logic [FRAME_W:0] word;
        word = {1'b1, sa, cmd, addr, (~^{sa, cmd, addr}) ^ bad, data, ~^data};
        for (int i = FRAME_W; i >= 0; i--) put_bit(word[i]);
        // Park low half a period on, so a next frame never moves the line in one step
        #HALF sdata_out = 1'b0;
        #HALF;
    endtask : send_frame
endmodule : rffe_bus_master

// [sim/test_rffe_switch_power_state_control.sv]
`timescale 1ns/1ps
`define CHK(got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        errors++; \
        $display("[ERR] t=%0t got=%0h exp=%0h", $time, (got), (exp)); \
    end \
end

module test_rffe_switch_power_state_control
    import rffe_switch_pkg::*;
();
    // ----------------------------------------
    // Bench signals and instances
    // ----------------------------------------
    localparam logic [3:0] DEV_ID = 4'h7; // Arbitrary slave address
    logic clock_in = 1'b0;
    logic rst_in;
    logic vio_in;
    logic sclk_in;
    logic sdata_in;
    logic [5:0] bank_a;
    logic [5:0] bank_b;
    logic paths_valid;
    logic pump;
    logic slave_live;
    logic [1:0] state_out;
    int errors = 0;
    int checks_done = 0;

    always #10 clock_in = ~clock_in;

    rffe_bus_master i_master (.sclk_out(sclk_in), .sdata_out(sdata_in));
    rffe_switch_power_state_control #(.SLAVE_ID(DEV_ID)) i_dut (
        .clock_in(clock_in), .rst_in(rst_in), .sclk_in(sclk_in), .sdata_in(sdata_in),
        .vio_in(vio_in), .bank_a_throw_port_out(bank_a), .bank_b_throw_port_out(bank_b),
        .paths_valid_out(paths_valid), .charge_pump_en_out(pump),
        .slave_active_out(slave_live), .state_out(state_out));

    function automatic logic [5:0] hot(input logic [2:0] s);
        return (s >= 3'h1 && s <= 3'h6) ? 6'h01 << (s - 3'h1) : 6'h00;
    endfunction : hot

    // Sampled 1 ns after the edge so the output flops have landed
    task automatic chk_out(input op_state_t st, input logic [5:0] a, input logic [5:0] b);
        logic act;
        logic live;
        act = (st == ST_ACTIVE);
        live = (st == ST_ACTIVE) || (st == ST_LOW_POWER);
        #1;
        `CHK(state_out, st)
        `CHK(bank_a, a)
        `CHK(bank_b, b)
        `CHK(pump, act)
        `CHK(paths_valid, act)
        `CHK(slave_live, live)
    endtask : chk_out

    task automatic wait_state(input op_state_t st, input int lim);
        int n;
        n = 0;
        while (state_out !== st && n < lim) begin
            @(negedge clock_in);
            n++;
        end
    endtask : wait_state

    // Frame effect needs about four system cycles; ten leaves margin
    task automatic wr(input logic [4:0] addr, input logic [7:0] data);
        i_master.send_frame(DEV_ID, CMD_REG_WRITE, addr, data, 1'b0);
        repeat (10) @(posedge clock_in);
    endtask : wr

    task automatic t_powerup();
        @(posedge clock_in) vio_in <= 1'b1;
        wait_state(ST_STARTUP, 20);
        chk_out(ST_STARTUP, 6'h00, 6'h00);
        repeat (STARTUP_CYCLES - 100) @(posedge clock_in);
        chk_out(ST_STARTUP, 6'h00, 6'h00);
        wait_state(ST_ACTIVE, 200);
        chk_out(ST_ACTIVE, 6'h00, 6'h00);
    endtask : t_powerup

    task automatic t_select();
        for (int s = 0; s < 8; s++) begin
            wr(REG_BANK_A, {5'h00, 3'(s)});
            wr(REG_BANK_B, {5'h00, 3'(7 - s)});
            chk_out(ST_ACTIVE, hot(3'(s)), hot(3'(7 - s)));
        end
        i_master.send_frame(DEV_ID, CMD_REG_WRITE, REG_BANK_A, 8'h02, 1'b0);
        wr(REG_BANK_B, 8'h05);
        chk_out(ST_ACTIVE, hot(3'h2), hot(3'h5));
    endtask : t_select

    task automatic t_refused();
        i_master.send_frame(DEV_ID, CMD_REG_WRITE, REG_BANK_A, 8'h04, 1'b1);
        i_master.send_frame(DEV_ID ^ 4'h1, CMD_REG_WRITE, REG_BANK_A, 8'h04, 1'b0);
        i_master.send_frame(DEV_ID, 3'h3, REG_BANK_A, 8'h04, 1'b0);
        wr(5'h05, 8'h04);
        chk_out(ST_ACTIVE, hot(3'h2), hot(3'h5));
        i_master.send_frame(SA_BROADCAST, CMD_REG_WRITE, REG_BANK_A, 8'h04, 1'b0);
        repeat (10) @(posedge clock_in);
        chk_out(ST_ACTIVE, hot(3'h4), hot(3'h5));
    endtask : t_refused

    task automatic t_low_power();
        wr(REG_POWER, {PWR_LOW, 6'h00});
        chk_out(ST_LOW_POWER, 6'h00, 6'h00);
        wr(REG_BANK_A, 8'h01);
        wr(REG_POWER, 8'hC0);
        chk_out(ST_LOW_POWER, 6'h00, 6'h00);
        wr(REG_POWER, {PWR_ACTIVE, 6'h00});
        chk_out(ST_ACTIVE, hot(3'h1), hot(3'h5));
        wr(REG_POWER, {PWR_STARTUP, 6'h00});
        chk_out(ST_STARTUP, 6'h00, 6'h00);
        wait_state(ST_ACTIVE, STARTUP_CYCLES + 20);
        chk_out(ST_ACTIVE, 6'h00, 6'h00);
        wr(REG_POWER, {PWR_LOW, 6'h00});
        chk_out(ST_LOW_POWER, 6'h00, 6'h00);
        wr(REG_POWER, {PWR_STARTUP, 6'h00});
        chk_out(ST_STARTUP, 6'h00, 6'h00);
        wait_state(ST_ACTIVE, STARTUP_CYCLES + 20);
        chk_out(ST_ACTIVE, 6'h00, 6'h00);
    endtask : t_low_power

    task automatic t_vio_loss();
        wr(REG_BANK_A, 8'h03);
        chk_out(ST_ACTIVE, hot(3'h3), 6'h00);
        @(posedge clock_in) vio_in <= 1'b0;
        repeat (8) @(posedge clock_in);
        chk_out(ST_SHUTDOWN, 6'h00, 6'h00);
        wr(REG_POWER, {PWR_ACTIVE, 6'h00});
        chk_out(ST_SHUTDOWN, 6'h00, 6'h00);
        @(posedge clock_in) vio_in <= 1'b1;
        wait_state(ST_STARTUP, 20);
        wait_state(ST_ACTIVE, STARTUP_CYCLES + 20);
        chk_out(ST_ACTIVE, 6'h00, 6'h00);
    endtask : t_vio_loss

    task automatic final_report();
        $display("Checks made: %0d, mismatches: %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : final_report

    // Link side only sees reset through its own clock, so idle bits run during reset
    initial begin
        rst_in = 1'b1;
        vio_in = 1'b0;
        i_master.idle(4);
        @(posedge clock_in) rst_in <= 1'b0;
        // The receiver drops its reset only on sclk edges, so idle bits follow the release
        i_master.idle(4);
        t_powerup();
        t_select();
        t_refused();
        t_low_power();
        t_vio_loss();
        final_report();
    end

    // Whole run needs about 70 us; over five times that means a hang
    initial begin
        #400us;
        errors++;
        final_report();
    end
endmodule : test_rffe_switch_power_state_control
